// File: dspic_cfg.svh
/*
 * Register offsets, field positions and reset values for the port and
 * interrupt control block of the dual serial controller.
 * Assumes a 4-bit register address and 8-bit data bus.
 */
`ifndef DSPIC_CFG_SVH
`define DSPIC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DSPIC_ADDR_AUX_CONTROL    4'h4
`define DSPIC_ADDR_INPUT_CHANGE   4'h4
`define DSPIC_ADDR_INT_STATUS     4'h5
`define DSPIC_ADDR_INT_MASK       4'h5
`define DSPIC_ADDR_OUTPUT_CONFIG  4'hd
`define DSPIC_ADDR_OUTPUT_SET     4'he
`define DSPIC_ADDR_OUTPUT_CLEAR   4'hf

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DSPIC_AUX_BAUD_SET_BIT    7
`define DSPIC_AUX_CT_MSB          6
`define DSPIC_AUX_CT_LSB          4
`define DSPIC_AUX_CT_TIMER_BIT    6
`define DSPIC_STS_INPUT_CHANGE    7
`define DSPIC_STS_BREAK_B         6
`define DSPIC_STS_RX_B            5
`define DSPIC_STS_TX_B            4
`define DSPIC_STS_COUNTER         3
`define DSPIC_STS_BREAK_A         2
`define DSPIC_STS_RX_A            1
`define DSPIC_STS_TX_A            0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSPIC_RST_BYTE            8'h00
`define DSPIC_RST_NIBBLE          4'h0

`endif

// File: dspic_checker.sv
/* Port checks on dspic_top.
   Assumes no set or clear write while the output source config register is non-zero. */
`timescale 1ns/10ps
module dspic_checker (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic       cs_in,
  input wire logic       rd_in,
  input wire logic       wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic       break_edge_a_in,
  input wire logic       reset_break_a_in,
  input wire logic       counter_terminal_in,
  input wire logic       stop_counter_in,
  input wire logic       timer_zero_in,
  input wire logic [7:0] output_pins_out,
  input wire logic       interrupt_pin_n_out,
  input wire logic       baud_set_out,
  input wire logic       ct_timer_mode_out,
  input wire logic [7:0] interrupt_status_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire wr_set  = cs_in && wr_in && addr_in == 4'he;
  wire wr_clr  = cs_in && wr_in && addr_in == 4'hf;
  wire wr_aux  = cs_in && wr_in && addr_in == 4'h4;
  wire rd_any  = cs_in && rd_in;
  sequence s_rd_chg;
    rd_any && addr_in == 4'h4 && !break_edge_a_in;
  endsequence
  sequence s_rd_sts;
    rd_any && addr_in == 4'h5;
  endsequence
  a_set_bits: assert property (wr_set |=> (output_pins_out & $past(wdata_in)) == 8'h00)
    else $error("set write left a pin high");
  a_clear_bits: assert property (wr_clr |=> (~output_pins_out & $past(wdata_in)) == 8'h00)
    else $error("clear write left a pin low");
  a_keep_other: assert property (wr_set |=> ((output_pins_out ^ $past(output_pins_out))
    & ~$past(wdata_in)) == 8'h00)
    else $error("set write moved an unselected pin");
  a_aux_fields: assert property (wr_aux |=> baud_set_out == $past(wdata_in[7])
    && ct_timer_mode_out == $past(wdata_in[6]))
    else $error("aux fields not taken from write");
  a_chg_read: assert property (s_rd_chg |=> !interrupt_status_out[7])
    else $error("change read kept status bit 7");
  a_sts_read: assert property (s_rd_sts |=> rdata_out == $past(interrupt_status_out))
    else $error("status read differs from status");
  a_rdata_idle: assert property (!rd_any |=> rdata_out == 8'h00)
    else $error("read data not idle");
  a_irq_quiet: assert property (interrupt_status_out == 8'h00 |-> interrupt_pin_n_out)
    else $error("interrupt pin low with no status");
  a_break_set: assert property (break_edge_a_in |=> interrupt_status_out[2])
    else $error("break change not set");
  a_break_hold: assert property (interrupt_status_out[2] && !reset_break_a_in
    |=> interrupt_status_out[2])
    else $error("break change dropped without command");
  a_break_clr: assert property (reset_break_a_in && !break_edge_a_in
    |=> !interrupt_status_out[2])
    else $error("break change not cleared");
  a_count_set: assert property (counter_terminal_in && !ct_timer_mode_out
    |=> interrupt_status_out[3])
    else $error("counter ready not set");
  a_stop_clr: assert property (stop_counter_in && !counter_terminal_in && !timer_zero_in
    |=> !interrupt_status_out[3])
    else $error("stop left counter ready set");
endmodule

bind dspic_top dspic_checker i_dspic_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .cs_in(cs_in), .rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata_in),
  .rdata_out(rdata_out), .break_edge_a_in(break_edge_a_in),
  .reset_break_a_in(reset_break_a_in), .counter_terminal_in(counter_terminal_in),
  .stop_counter_in(stop_counter_in), .timer_zero_in(timer_zero_in),
  .output_pins_out(output_pins_out), .interrupt_pin_n_out(interrupt_pin_n_out),
  .baud_set_out(baud_set_out), .ct_timer_mode_out(ct_timer_mode_out),
  .interrupt_status_out(interrupt_status_out));

// File: dspic_chg_detect.sv
/*
 * Change-of-state detector for four input pins: two-stage synchroniser,
 * then a compare of successive synchronised samples.
 * Assumes raw pins are asynchronous to clk_in.
 */
`timescale 1ns/10ps
module dspic_chg_detect (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] pins_in,
  dspic_chg_if.detector   chg
);
  `include "dspic_cfg.svh"

  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] prev_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= `DSPIC_RST_NIBBLE;
      sync_reg <= `DSPIC_RST_NIBBLE;
      prev_reg <= `DSPIC_RST_NIBBLE;
    end else begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign chg.level  = sync_reg;
  assign chg.change = sync_reg ^ prev_reg;
endmodule

// File: dspic_chg_if.sv
/*
 * Interface carrying the change-of-state detector results to the top.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface dspic_chg_if;
  logic [3:0] level;
  logic [3:0] change;
  modport detector (output level, output change);
  modport user     (input level, input change);
endinterface

// File: dspic_host.sv
/* Host bus model with one-cycle strobes.
   Assumes read data is valid the cycle after the read edge. */
`timescale 1ns/10ps
module dspic_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [3:0] addr_out,
  output logic            cs_out,
  output logic            rd_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out
);
  initial begin
    addr_out = 4'h0;
    cs_out = 1'b0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  // Released data and address are inverted so nothing stale looks valid.
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    cs_out <= 1'b1;
    wr_out <= 1'b1;
    @(posedge clk_in);
    cs_out <= 1'b0;
    wr_out <= 1'b0;
    wdata_out <= ~d;
    addr_out <= ~a;
    #1;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    cs_out <= 1'b1;
    rd_out <= 1'b1;
    @(posedge clk_in);
    cs_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule

// File: dspic_pkg.sv
/*
 * Types shared by the port and interrupt control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dspic_pkg;
  typedef enum logic [2:0] {
    DSPIC_CNT_PIN2,
    DSPIC_CNT_TXA,
    DSPIC_CNT_TXB,
    DSPIC_CNT_OSC16,
    DSPIC_TMR_PIN2,
    DSPIC_TMR_PIN2_16,
    DSPIC_TMR_OSC,
    DSPIC_TMR_OSC16
  } dspic_ct_sel_t;

  typedef enum logic [1:0] {
    DSPIC_SRC_PIN,
    DSPIC_SRC_TXBIT,
    DSPIC_SRC_OSC,
    DSPIC_SRC_OSC16
  } dspic_ct_src_t;
endpackage

// File: dspic_top.sv
/*
 * Port and interrupt control of a dual serial controller: output latch
 * with bit set/clear writes, input change register, auxiliary control,
 * interrupt status and mask driving one active-low interrupt pin.
 * Assumes a host bus with 4-bit address, chip select, read and write
 * strobes (one cycle each, synchronous to clk_in), and event inputs from
 * the channels and counter/timer on the same clock.
 */
// What this block does
// RULE1: Writing output-set register sets every latch bit where data is one.
// RULE2: Writing output-clear register clears every latch bit where data is one.
// RULE3: Latch-sourced output pins show the inverse of their latch bit.
// RULE4: Aux control bit 7 selects one of two baud-rate sets.
// RULE5: Aux codes 000-011 pick counter mode with pin2, txA, txB, osc/16 clocks; code drives the same DSPIC_SRC_TXBIT source for txA and txB.
// RULE6: Aux codes 100-111 pick timer mode with pin2, pin2/16, osc, osc/16.
// RULE7: Aux bits 3-0 enable which input changes set the input-change status.
// RULE8: Change bits 7-4 set on pin change, all cleared on register read.
// RULE9: Reading the input-change register also clears status bit 7.
// RULE10: Change register bits 3-0 show live input pin levels.
// RULE11: Interrupt pin low when any status bit and its mask bit are set.
// RULE12: Status reads return unmasked status.
// RULE13: Status resets to zero with the documented bit order.
// RULE14: Break-change status sets on break start or end, cleared by command.
// RULE15: Receive status follows fill level or watchdog expiry.
// RULE16: Transmit status follows transmit fifo level, not ready bit.
// RULE17: Counter mode: ready sets at terminal count, stop command clears it.
// RULE18: Timer mode: ready sets each square-wave cycle, stop clears, runs on.
// RULE19: Mask gates only the interrupt pin, not pin outputs or reads.
// RULE20: Output pins 7-2 show inverted latch until configuration selects otherwise.
// RULE21: Host writes aux/mask, reads change/status at shared addresses.
`timescale 1ns/10ps
module dspic_top
  import dspic_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] addr_in,
  input  wire logic       cs_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  input  wire logic [3:0] input_pins_in,
  input  wire logic       rx_irq_chan_a_in,
  input  wire logic       rx_irq_chan_b_in,
  input  wire logic       tx_irq_chan_a_in,
  input  wire logic       tx_irq_chan_b_in,
  input  wire logic       break_edge_a_in,
  input  wire logic       break_edge_b_in,
  input  wire logic       reset_break_a_in,
  input  wire logic       reset_break_b_in,
  input  wire logic       counter_terminal_in,
  input  wire logic       timer_zero_in,
  input  wire logic       stop_counter_in,
  input  wire logic [7:0] alt_source_in,
  output logic      [7:0] output_pins_out,
  output logic            interrupt_pin_n_out,
  output logic            baud_set_out,
  output logic            ct_timer_mode_out,
  output logic      [1:0] ct_clock_src_out,
  output logic            ct_prescale16_out,
  output logic      [7:0] interrupt_status_out
);
  `include "dspic_cfg.svh"

  // --------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------
  logic [7:0] output_latch_reg;
  logic [7:0] output_latch_next;
  logic [7:0] aux_control_reg;
  logic [7:0] interrupt_mask_reg;
  logic [7:0] output_config_reg;
  logic [3:0] input_change_reg;
  logic [3:0] input_change_next;
  logic       change_int_reg;
  logic       change_int_next;
  logic       break_a_reg;
  logic       break_b_reg;
  logic       counter_ready_reg;
  logic       counter_ready_next;
  logic       timer_half_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] status_live;
  logic [3:0] change_enabled;
  logic [7:0] irq_hits;

  dspic_chg_if chg ();

  dspic_chg_detect i_dspic_chg_detect (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .pins_in  (input_pins_in),
    .chg      (chg)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  // Offsets 4 and 5 name different registers for writes and for reads.
  wire wr_stb       = cs_in & wr_in;
  wire rd_stb       = cs_in & rd_in;
  wire wr_set       = wr_stb & hit(addr_in, `DSPIC_ADDR_OUTPUT_SET);
  wire wr_clear     = wr_stb & hit(addr_in, `DSPIC_ADDR_OUTPUT_CLEAR);
  wire wr_aux       = wr_stb & hit(addr_in, `DSPIC_ADDR_AUX_CONTROL);   // RULE21
  wire wr_mask      = wr_stb & hit(addr_in, `DSPIC_ADDR_INT_MASK);      // RULE21
  wire wr_config    = wr_stb & hit(addr_in, `DSPIC_ADDR_OUTPUT_CONFIG);
  wire rd_change    = rd_stb & hit(addr_in, `DSPIC_ADDR_INPUT_CHANGE);  // RULE21
  wire rd_status    = rd_stb & hit(addr_in, `DSPIC_ADDR_INT_STATUS);
  wire timer_mode   = aux_control_reg[`DSPIC_AUX_CT_TIMER_BIT];

  // --------------------------------------------------------------------
  // Output latch
  // --------------------------------------------------------------------
  // Set and clear never coincide since they are separate addresses.
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_latch
      assign output_latch_next[i] = (wr_set & wdata_in[i])   ? 1'b1         // RULE1
                                  : (wr_clear & wdata_in[i]) ? 1'b0         // RULE2
                                  : output_latch_reg[i];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Input change and status bits
  // --------------------------------------------------------------------
  // Pin changes land here three edges after the pin moves: two sync stages and a compare.
  // A change arriving in the read cycle survives the clear.
  assign input_change_next = (rd_change ? `DSPIC_RST_NIBBLE : input_change_reg)
                           | chg.change;                                      // RULE8
  assign change_enabled    = chg.change & aux_control_reg[3:0];               // RULE7
  assign change_int_next   = (rd_change ? 1'b0 : change_int_reg)              // RULE9
                           | (|change_enabled);                               // RULE7

  // --------------------------------------------------------------------
  // Counter ready
  // --------------------------------------------------------------------
  // Timer mode sets the flag on every second zero count, once per square-wave cycle.
  wire ct_event = timer_mode ? (timer_zero_in & timer_half_reg)               // RULE18
                             : counter_terminal_in;                           // RULE17
  assign counter_ready_next = (stop_counter_in ? 1'b0 : counter_ready_reg) | ct_event;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter_ready_reg <= 1'b0;
      timer_half_reg    <= 1'b0;
    end else begin
      counter_ready_reg <= counter_ready_next;
      if (timer_zero_in && timer_mode) begin
        timer_half_reg <= ~timer_half_reg;
      end
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      output_latch_reg <= `DSPIC_RST_BYTE;
    end else begin
      output_latch_reg <= output_latch_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_change_reg <= `DSPIC_RST_NIBBLE;
      change_int_reg   <= 1'b0;                                           // RULE13
    end else begin
      input_change_reg <= input_change_next;
      change_int_reg   <= change_int_next;
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_control_reg <= `DSPIC_RST_BYTE;
    end else if (wr_aux) begin
      aux_control_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_mask_reg <= `DSPIC_RST_BYTE;
    end else if (wr_mask) begin
      interrupt_mask_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      output_config_reg <= `DSPIC_RST_BYTE;                               // RULE20
    end else if (wr_config) begin
      output_config_reg <= wdata_in;
    end
  end

  // Break flags: the edge wins over a same-cycle reset command.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      break_a_reg <= 1'b0;
    end else begin
      break_a_reg <= (break_a_reg & ~reset_break_a_in) | break_edge_a_in;   // RULE14
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      break_b_reg <= 1'b0;
    end else begin
      break_b_reg <= (break_b_reg & ~reset_break_b_in) | break_edge_b_in;   // RULE14
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------
  assign status_live = {change_int_reg,                                     // RULE13
                        break_b_reg,
                        rx_irq_chan_b_in,                                   // RULE15
                        tx_irq_chan_b_in,                                   // RULE16
                        counter_ready_reg,
                        break_a_reg,
                        rx_irq_chan_a_in,                                   // RULE15
                        tx_irq_chan_a_in};                                  // RULE16

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Read data stands for one cycle and then returns to zero.
  assign rdata_next = rd_change ? {input_change_reg, chg.level}             // RULE10
                    : rd_status ? status_live                               // RULE12
                    : `DSPIC_RST_BYTE;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= `DSPIC_RST_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  // --------------------------------------------------------------------
  // Pins and counter/timer selection
  // --------------------------------------------------------------------
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // Alternate sources are unmasked dedicated outputs.
      assign output_pins_out[i] = output_config_reg[i] ? alt_source_in[i]   // RULE19
                                : ~output_latch_reg[i];                     // RULE3
    end
  endgenerate

  assign irq_hits             = status_live & interrupt_mask_reg;           // RULE19
  assign interrupt_pin_n_out  = ~(|irq_hits);                               // RULE11
  assign interrupt_status_out = status_live;                                // RULE19
  assign baud_set_out         = aux_control_reg[`DSPIC_AUX_BAUD_SET_BIT];   // RULE4
  assign ct_timer_mode_out    = timer_mode;

  dspic_ct_sel_t ct_sel;
  assign ct_sel = dspic_ct_sel_t'(aux_control_reg[`DSPIC_AUX_CT_MSB:`DSPIC_AUX_CT_LSB]);

  always_comb begin
    ct_clock_src_out  = DSPIC_SRC_PIN;
    ct_prescale16_out = 1'b0;
    case (ct_sel)
      DSPIC_CNT_PIN2: begin                                                 // RULE5
        ct_clock_src_out = DSPIC_SRC_PIN;
      end
      DSPIC_CNT_TXA: begin
        ct_clock_src_out = DSPIC_SRC_TXBIT;
      end
      DSPIC_CNT_TXB: begin
        ct_clock_src_out = DSPIC_SRC_TXBIT;
        ct_prescale16_out = 1'b0;
      end
      DSPIC_CNT_OSC16: begin
        ct_clock_src_out  = DSPIC_SRC_OSC16;
      end
      DSPIC_TMR_PIN2: begin                                                 // RULE6
        ct_clock_src_out = DSPIC_SRC_PIN;
      end
      DSPIC_TMR_PIN2_16: begin
        ct_clock_src_out  = DSPIC_SRC_PIN;
        ct_prescale16_out = 1'b1;
      end
      DSPIC_TMR_OSC: begin
        ct_clock_src_out = DSPIC_SRC_OSC;
      end
      DSPIC_TMR_OSC16: begin
        ct_clock_src_out = DSPIC_SRC_OSC16;
      end
      default: begin
        ct_clock_src_out = DSPIC_SRC_PIN;
      end
    endcase
  end
endmodule

// File: dspic_top_tb.sv
/* Self-checking bench for dspic_top.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dspic_top_tb;
  import dspic_pkg::*;
  logic       clk_in;
  logic       rst_n_in;
  logic [3:0] addr, pins;
  logic       cs, rd, wr, rxa, rxb, txa, txb, irq_n, baud, tmode, pre;
  logic [7:0] wdata, rdata, opins, sts, d, alt;
  logic [6:0] ev;
  logic [1:0] src;
  int         err_count, tests_run, cyc;
  logic [1:0] src_tab [8] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h0, 2'h0, 2'h2, 2'h3};
  dspic_host i_dspic_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .cs_out(cs),
    .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
  dspic_top i_dspic_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .cs_in(cs),
    .rd_in(rd), .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata), .input_pins_in(pins),
    .rx_irq_chan_a_in(rxa), .rx_irq_chan_b_in(rxb), .tx_irq_chan_a_in(txa),
    .tx_irq_chan_b_in(txb), .break_edge_a_in(ev[0]), .break_edge_b_in(ev[1]),
    .reset_break_a_in(ev[2]), .reset_break_b_in(ev[3]), .counter_terminal_in(ev[4]),
    .timer_zero_in(ev[5]), .stop_counter_in(ev[6]), .alt_source_in(alt),
    .output_pins_out(opins), .interrupt_pin_n_out(irq_n), .baud_set_out(baud),
    .ct_timer_mode_out(tmode), .ct_clock_src_out(src), .ct_prescale16_out(pre),
    .interrupt_status_out(sts));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic pulse(input int b);
    @(posedge clk_in);
    ev[b] <= 1'b1;
    @(posedge clk_in);
    ev[b] <= 1'b0;
    #1;
  endtask
  task automatic t_reset();
    `CHK("pins", 8'hff, opins)
    `CHK("status", 8'h00, sts)
    `CHK("irq", 1'b1, irq_n)
    $display("done reset");
  endtask
  task automatic t_latch();
    i_dspic_host.bus_wr(4'he, 8'ha5);
    `CHK("pins set", 8'h5a, opins)
    i_dspic_host.bus_wr(4'he, 8'h02);
    `CHK("pins set2", 8'h58, opins)
    i_dspic_host.bus_wr(4'hf, 8'h81);
    `CHK("pins clr", 8'hd9, opins)
    i_dspic_host.bus_wr(4'hd, 8'hf0);
    `CHK("pins cfg", 8'h09, opins)
    @(posedge clk_in);
    alt <= 8'h50;
    @(posedge clk_in);
    #1;
    `CHK("pins alt", 8'h59, opins)
    i_dspic_host.bus_wr(4'hd, 8'h00);
    `CHK("pins back", 8'hd9, opins)
    $display("done latch");
  endtask
  task automatic t_aux();
    for (int i = 0; i < 8; i++) begin
      i_dspic_host.bus_wr(4'h4, {i[0], i[2:0], 4'h0});
      `CHK("baud", i[0], baud)
      `CHK("mode", i[2], tmode)
      `CHK("src", src_tab[i], src)
      `CHK("pre", (i == 5), pre)
    end
    $display("done aux");
  endtask
  task automatic t_change();
    i_dspic_host.bus_wr(4'h4, 8'h02);
    i_dspic_host.bus_wr(4'h5, 8'h80);
    @(posedge clk_in);
    pins <= 4'h2;
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("sts7", 1'b1, sts[7])
    `CHK("irq", 1'b0, irq_n)
    i_dspic_host.bus_rd(4'h4, d);
    `CHK("chg", 8'h22, d)
    `CHK("sts7 clr", 1'b0, sts[7])
    @(posedge clk_in);
    pins <= 4'h3;
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("sts7 off", 1'b0, sts[7])
    i_dspic_host.bus_rd(4'h4, d);
    `CHK("chg2", 8'h13, d)
    $display("done change");
  endtask
  task automatic t_status();
    i_dspic_host.bus_wr(4'h5, 8'h00);
    @(posedge clk_in);
    rxa <= 1'b1;
    txb <= 1'b1;
    @(posedge clk_in);
    #1;
    `CHK("irq masked", 1'b1, irq_n)
    i_dspic_host.bus_rd(4'h5, d);
    `CHK("sts rd", 8'h12, d)
    i_dspic_host.bus_wr(4'h5, 8'h10);
    `CHK("irq tx", 1'b0, irq_n)
    @(posedge clk_in);
    rxa <= 1'b0;
    txb <= 1'b0;
    rxb <= 1'b1;
    txa <= 1'b1;
    @(posedge clk_in);
    #1;
    `CHK("rx tx", 8'h21, sts)
    @(posedge clk_in);
    rxb <= 1'b0;
    txa <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      pulse(b);
      `CHK("brk", 1'b1, sts[b ? 6 : 2])
      pulse(b + 2);
      `CHK("brk clr", 1'b0, sts[b ? 6 : 2])
    end
    i_dspic_host.bus_wr(4'h4, 8'h00);
    pulse(4);
    `CHK("cnt", 1'b1, sts[3])
    pulse(6);
    `CHK("cnt stop", 1'b0, sts[3])
    i_dspic_host.bus_wr(4'h4, 8'h40);
    pulse(5);
    `CHK("tmr one", 1'b0, sts[3])
    pulse(5);
    `CHK("tmr two", 1'b1, sts[3])
    pulse(6);
    `CHK("tmr stop", 1'b0, sts[3])
    i_dspic_host.bus_rd(4'h2, d);
    `CHK("unmapped", 8'h00, d)
    $display("done status");
  endtask
  initial begin
    cyc = 0;
    forever @(posedge clk_in) begin
      cyc++;
      if (cyc > 3000) begin
        err_count++;
        summarize();
      end
    end
  end
  initial begin
    rst_n_in = 1'b0;
    pins = 4'h0;
    {rxa, rxb, txa, txb} = 4'h0;
    ev = 7'h00;
    alt = 8'h00;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    t_reset();
    t_latch();
    t_aux();
    t_change();
    t_status();
    summarize();
  end
endmodule
